/* xr_pkg.sv */
/*
  constants shared by both ends of the asynchronous exception and reset unit:
  exception vectors, machine state bit positions, reset values and timing counts.
  assumes a single 20 MHz clock on both ends; one bus cycle equals one clock.
*/
package xr_pkg;

  localparam int CLK_PERIOD_NS   = 50;
  localparam int FLOAT_MAX_CLK   = 5;
  localparam int WARM_MIN_BUS    = 2;
  localparam int BUS_CLK_RATIO   = 1;
  localparam int WARM_MIN_CYC    = WARM_MIN_BUS * BUS_CLK_RATIO;
  localparam int EXT_MIN_CYC     = 3;
  localparam int COLD_HOLD_US    = 100;
  localparam int COLD_HOLD_CYC   = (COLD_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_CYC        = 16;

  localparam logic [31:0] VEC_RESET      = 32'h0000_0100;
  localparam logic [31:0] VEC_MACH_CHECK = 32'h0000_0200;
  localparam logic [31:0] VEC_EXT_IRQ    = 32'h0000_0500;
  localparam logic [31:0] VEC_SYSMGMT    = 32'h0000_1400;
  localparam logic [31:0] VEC_BASE_HIGH  = 32'hFFF0_0000;
  localparam logic [31:0] VEC_BASE_LOW   = 32'h0000_0000;

  localparam int MSR_EE = 15;
  localparam int MSR_ME = 12;
  localparam int MSR_IP = 6;
  localparam int MSR_IR = 5;
  localparam int MSR_DR = 4;
  localparam logic [31:0] MSR_HARD_VAL = 32'h0000_0040;

  // index of each asynchronous input inside the synchroniser vector
  localparam int IN_W    = 9;
  localparam int IN_EXT  = 0;
  localparam int IN_SMI  = 1;
  localparam int IN_WARM = 2;
  localparam int IN_COLD = 3;
  localparam int IN_MCP  = 4;
  localparam int IN_TEA  = 5;
  localparam int IN_APE  = 6;
  localparam int IN_DPE  = 7;
  localparam int IN_HALT = 8;

  typedef enum logic [1:0] {
    XR_ST_FLOAT = 2'b00,
    XR_ST_INIT  = 2'b01,
    XR_ST_RUN   = 2'b10,
    XR_ST_HALT  = 2'b11
  } xr_state_e;

  function automatic logic [31:0] xr_vec(input logic ip, input logic [31:0] off);
    xr_vec = (ip ? VEC_BASE_HIGH : VEC_BASE_LOW) | off;
  endfunction : xr_vec

endpackage : xr_pkg

/* xr_if.sv */
/*
  pins between the system logic and the processor exception unit.
  status inputs are active low; the two device outputs are open drain with
  pull-ups, resolved here from their output enables.
*/
`timescale 1ns/1ps
interface xr_if;
  logic cold_reset_in_n;
  logic warm_reset_in_n;
  logic sysmgmt_irq_in_n;
  logic ext_irq_in_n;
  logic mach_check_in_n;
  logic transfer_error_ack_n;
  logic addr_parity_err_n;
  logic data_parity_err_n;
  logic halt_in_n;
  logic halt_out_o;
  logic halt_out_oe;
  logic bus_request_o;
  logic bus_request_oe;
  logic halt_out_n;
  logic bus_request_in_n;

  // pull-ups: a floating line reads as negated
  assign halt_out_n       = halt_out_oe ? halt_out_o : 1'b1;
  assign bus_request_in_n = bus_request_oe ? bus_request_o : 1'b1;

  modport dev (
    input  cold_reset_in_n, warm_reset_in_n, sysmgmt_irq_in_n, ext_irq_in_n,
    input  mach_check_in_n, transfer_error_ack_n, addr_parity_err_n,
    input  data_parity_err_n, halt_in_n,
    output halt_out_o, halt_out_oe, bus_request_o, bus_request_oe
  );
  modport sys (
    output cold_reset_in_n, warm_reset_in_n, sysmgmt_irq_in_n, ext_irq_in_n,
    output mach_check_in_n, transfer_error_ack_n, addr_parity_err_n,
    output data_parity_err_n, halt_in_n,
    input  halt_out_n, bus_request_in_n, halt_out_oe, bus_request_oe
  );
endinterface : xr_if

/* xr_sync.sv */
/*
  two-flop synchroniser for a vector of asynchronous levels.
  assumes the sources are slow levels; bits are not coherent with each other.
*/
`timescale 1ns/1ps
module xr_sync #(
  parameter int          W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_next;

  always_comb begin
    meta_next = d;
    q_next    = meta_reg;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= RST_VAL;
      q        <= RST_VAL;
    end else begin
      meta_reg <= meta_next;
      q        <= q_next;
    end
  end
endmodule : xr_sync

/* xr_dev.sv */
/*
  processor end of the asynchronous exception and reset unit: ranks resets,
  machine check, system management and external interrupts, sequences hard and
  soft reset, and keeps the machine state and save registers.
  assumes the core supplies the current pc and a flag for pending synchronous
  exceptions, and consumes exc_take/exc_vector as a redirect of fetch.
*/
`timescale 1ns/1ps

// How it works
// - hard reset, halt, machine check, soft reset outrank rest
// - system management below synchronous, above external
// - external interrupt ranks under system management
// - external vectors 0x500; short pulse latched pending
// - system management vectors 0x1400; optional by parameter
// - machine check uses vector 0x200; halt takes no vector
// - cold reset floats outputs within five clocks
// - system holds warm reset two bus cycles
// - hard reset initialises then fetches 0xFFF00100
// - warm reset saves state, resets msr, vector 0x100
// - system holds cold reset through supply and lock
// - outputs float during cold reset and init
// - system ignores lines while they float
// - bus request reads negated during initialisation
// - hard reset enables external halt recognition
// - after hard reset, pins go to functional logic
// - reset clears data and instruction translation bits
// - hard reset sets vector prefix select bit
module xr_dev
  import xr_pkg::*;
#(
  parameter int HAS_SYSMGMT = 1,
  parameter int HAS_MCP     = 1,
  parameter int INIT_LEN    = INIT_CYC
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  xr_if.dev                pins,
  input  wire logic [31:0] pc_in,
  input  wire logic        sync_exc_pending,
  input  wire logic        msr_wr,
  input  wire logic [31:0] msr_wdata,
  input  wire logic        bus_req_user,
  output logic             exc_take,
  output logic      [31:0] exc_vector,
  output logic      [31:0] save_pc_reg,
  output logic      [31:0] save_state_reg,
  output logic      [31:0] machine_state_reg,
  output logic             halt_enabled,
  output logic             io_functional,
  output logic             halted
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisation

  logic [IN_W-1:0] raw_n;
  logic [IN_W-1:0] syn_n;

  assign raw_n[IN_EXT]  = pins.ext_irq_in_n;
  assign raw_n[IN_SMI]  = pins.sysmgmt_irq_in_n;
  assign raw_n[IN_WARM] = pins.warm_reset_in_n;
  assign raw_n[IN_COLD] = pins.cold_reset_in_n;
  assign raw_n[IN_MCP]  = pins.mach_check_in_n;
  assign raw_n[IN_TEA]  = pins.transfer_error_ack_n;
  assign raw_n[IN_APE]  = pins.addr_parity_err_n;
  assign raw_n[IN_DPE]  = pins.data_parity_err_n;
  assign raw_n[IN_HALT] = pins.halt_in_n;

  // reset to all negated so nothing is seen as asserted out of reset
  xr_sync #(.W(IN_W), .RST_VAL({IN_W{1'b1}})) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .d    (raw_n),
    .q    (syn_n)
  );

  logic cold_act;
  logic warm_act;
  logic mc_act;
  logic halt_act;
  logic smi_act;
  logic ext_act;

  always_comb begin
    cold_act = !syn_n[IN_COLD];
    warm_act = !syn_n[IN_WARM];
    mc_act   = !syn_n[IN_TEA] || !syn_n[IN_APE] || !syn_n[IN_DPE]
               || ((HAS_MCP != 0) && !syn_n[IN_MCP]);
    halt_act = !syn_n[IN_HALT];
    smi_act  = (HAS_SYSMGMT != 0) && !syn_n[IN_SMI];
    ext_act  = !syn_n[IN_EXT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // state

  xr_state_e   state_reg,   state_next;
  logic [15:0] cnt_reg,     cnt_next;
  logic [31:0] msr_reg,     msr_next;
  logic [31:0] save_pc_reg_reg,    save_pc_reg_next;
  logic [31:0] save_state_reg_reg,    save_state_reg_next;
  logic        ckstp_reg,   ckstp_next;
  logic        iofunc_reg,  iofunc_next;
  logic        warm_d_reg,  warm_d_next;
  logic        mc_d_reg,    mc_d_next;
  logic        ext_pnd_reg, ext_pnd_next;
  logic        ext_d_reg,   ext_d_next;
  logic        take_reg,    take_next;
  logic [31:0] vec_reg,     vec_next;
  localparam logic [15:0] INIT_LAST = 16'(INIT_LEN - 1);
  // msr on entry of an asynchronous exception: clear EE, IR and DR; the callers save pc and msr
  function automatic logic [31:0] msr_on_entry(input logic [31:0] m);
    logic [31:0] r;
    r         = m;
    r[MSR_EE] = 1'b0;
    r[MSR_IR] = 1'b0;
    r[MSR_DR] = 1'b0;
    msr_on_entry = r;
  endfunction : msr_on_entry

  always_comb begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    msr_next     = msr_reg;
    save_pc_reg_next    = save_pc_reg_reg;
    save_state_reg_next    = save_state_reg_reg;
    ckstp_next   = ckstp_reg;
    iofunc_next  = iofunc_reg;
    warm_d_next  = warm_act;
    mc_d_next    = mc_act;
    ext_d_next   = ext_act;
    take_next    = 1'b0;
    vec_next     = vec_reg;
    // a short pulse is remembered by its edge; an edge in the cycle of an external take is cleared below
    ext_pnd_next = ext_pnd_reg;
    if (msr_wr && state_reg == XR_ST_RUN) begin
      msr_next = msr_wdata;
    end
    if (cold_act) begin
      // sync (2) + this register (1) = 3 clocks to float, inside the limit
      state_next   = XR_ST_FLOAT;
      cnt_next     = '0;
      msr_next     = MSR_HARD_VAL;
      save_pc_reg_next    = '0;
      save_state_reg_next    = '0;
      ckstp_next   = 1'b1;
      iofunc_next  = 1'b0;
      ext_pnd_next = 1'b0;
    end else begin
      case (state_reg)
        XR_ST_FLOAT: begin
          state_next = XR_ST_INIT;
          cnt_next   = '0;
        end
        XR_ST_INIT: begin
          // outputs stay floating while internal initialisation runs
          if (cnt_reg == INIT_LAST) begin
            state_next  = XR_ST_RUN;
            iofunc_next = 1'b1;
            take_next   = 1'b1;
            vec_next    = xr_vec(msr_reg[MSR_IP], VEC_RESET);
          end else begin
            cnt_next = cnt_reg + 16'd1;
          end
        end
        XR_ST_RUN: begin
          if (halt_act && ckstp_reg) begin
            state_next = XR_ST_HALT;
          end else if (mc_act && !mc_d_reg) begin
            if (msr_reg[MSR_ME]) begin
              save_pc_reg_next = pc_in;
              save_state_reg_next = msr_reg;
              msr_next  = msr_on_entry(msr_reg);
              msr_next[MSR_ME] = 1'b0;
              take_next = 1'b1;
              vec_next  = xr_vec(msr_reg[MSR_IP], VEC_MACH_CHECK);
            end else begin
              // machine check with recovery disabled stops the processor
              state_next = XR_ST_HALT;
            end
          end else if (warm_act && !warm_d_reg) begin
            save_pc_reg_next = pc_in;
            save_state_reg_next = msr_reg;
            msr_next  = '0;
            msr_next[MSR_IP] = msr_reg[MSR_IP];
            take_next = 1'b1;
            vec_next  = xr_vec(msr_reg[MSR_IP], VEC_RESET);
          end else if (!sync_exc_pending && msr_reg[MSR_EE]) begin
            if (smi_act) begin
              save_pc_reg_next = pc_in;
              save_state_reg_next = msr_reg;
              msr_next  = msr_on_entry(msr_reg);
              take_next = 1'b1;
              vec_next  = xr_vec(msr_reg[MSR_IP], VEC_SYSMGMT);
            end else if (ext_act || ext_pnd_reg) begin
              save_pc_reg_next    = pc_in;
              save_state_reg_next    = msr_reg;
              msr_next     = msr_on_entry(msr_reg);
              take_next    = 1'b1;
              ext_pnd_next = 1'b0;
              vec_next     = xr_vec(msr_reg[MSR_IP], VEC_EXT_IRQ);
            end
          end
        end
        XR_ST_HALT: begin
          // only a hard reset leaves the halted state
          state_next = XR_ST_HALT;
        end
        default: begin
          state_next = XR_ST_FLOAT;
        end
      endcase
      if (ext_act && !ext_d_reg && state_reg != XR_ST_FLOAT) begin
        ext_pnd_next = 1'b1;
      end
      if (ext_act && take_next && vec_next == xr_vec(msr_reg[MSR_IP], VEC_EXT_IRQ)) begin
        // the level that was just taken must not re-arm the latch
        ext_pnd_next = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg   <= XR_ST_FLOAT;
      cnt_reg     <= '0;
      msr_reg     <= MSR_HARD_VAL;
      save_pc_reg_reg    <= '0;
      save_state_reg_reg    <= '0;
      ckstp_reg   <= 1'b1;
      iofunc_reg  <= 1'b0;
      warm_d_reg  <= 1'b0;
      mc_d_reg    <= 1'b0;
      ext_d_reg   <= 1'b0;
      ext_pnd_reg <= 1'b0;
      take_reg    <= 1'b0;
      vec_reg     <= '0;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      msr_reg     <= msr_next;
      save_pc_reg_reg    <= save_pc_reg_next;
      save_state_reg_reg    <= save_state_reg_next;
      ckstp_reg   <= ckstp_next;
      iofunc_reg  <= iofunc_next;
      warm_d_reg  <= warm_d_next;
      mc_d_reg    <= mc_d_next;
      ext_d_reg   <= ext_d_next;
      ext_pnd_reg <= ext_pnd_next;
      take_reg    <= take_next;
      vec_reg     <= vec_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign exc_take          = take_reg;
  assign exc_vector        = vec_reg;
  assign save_pc_reg       = save_pc_reg_reg;
  assign save_state_reg    = save_state_reg_reg;
  assign machine_state_reg = msr_reg;
  assign halt_enabled      = ckstp_reg;
  assign io_functional     = iofunc_reg;
  assign halted            = (state_reg == XR_ST_HALT);
  // open drain: drive low only; the pull-up keeps it negated while floating
  assign pins.halt_out_o     = 1'b0;
  assign pins.halt_out_oe    = iofunc_reg && (state_reg == XR_ST_HALT);
  assign pins.bus_request_o  = 1'b0;
  assign pins.bus_request_oe = iofunc_reg && bus_req_user;

endmodule : xr_dev

/* xr_sys.sv */
/*
  system logic end: drives the reset, interrupt and error pins of the processor
  and watches its halt and bus request lines.
  assumes user requests are synchronous to clk; one bus cycle equals one clock.
*/
`timescale 1ns/1ps
module xr_sys
  import xr_pkg::*;
#(
  parameter int COLD_LEN = COLD_HOLD_CYC,
  parameter int WARM_LEN = WARM_MIN_CYC,
  parameter int EXT_LEN  = EXT_MIN_CYC
) (
  input  wire logic clk,
  input  wire logic nrst,
  xr_if.sys         pins,
  input  wire logic cold_req,
  input  wire logic warm_req,
  input  wire logic smi_req,
  input  wire logic ext_req,
  input  wire logic mcp_req,
  input  wire logic tea_req,
  input  wire logic ape_req,
  input  wire logic dpe_req,
  input  wire logic halt_req,
  output logic      cold_busy,
  output logic      warm_busy,
  output logic      dev_bus_req,
  output logic      dev_halted
);

  logic [15:0] cold_cnt_reg, cold_cnt_next;
  logic [15:0] warm_cnt_reg, warm_cnt_next;
  logic [15:0] ext_cnt_reg,  ext_cnt_next;
  logic        bus_req_reg,  bus_req_next;
  logic        halted_reg,   halted_next;

  // stretch a request: reload on request, then count down to zero
  function automatic logic [15:0] stretch(input logic req, input logic [15:0] cnt,
                                          input int len);
    if (req) begin
      stretch = 16'(len);
    end else if (cnt != 16'd0) begin
      stretch = cnt - 16'd1;
    end else begin
      stretch = cnt;
    end
  endfunction : stretch

  always_comb begin
    cold_cnt_next = stretch(cold_req, cold_cnt_reg, COLD_LEN);
    warm_cnt_next = stretch(warm_req, warm_cnt_reg, WARM_LEN);
    ext_cnt_next  = stretch(ext_req,  ext_cnt_reg,  EXT_LEN);
    // floating lines are not interpreted
    bus_req_next  = pins.bus_request_oe && !pins.bus_request_in_n;
    halted_next   = pins.halt_out_oe && !pins.halt_out_n;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cold_cnt_reg <= 16'(COLD_LEN); // power-on: hold cold reset
      warm_cnt_reg <= '0;
      ext_cnt_reg  <= '0;
      bus_req_reg  <= 1'b0;
      halted_reg   <= 1'b0;
    end else begin
      cold_cnt_reg <= cold_cnt_next;
      warm_cnt_reg <= warm_cnt_next;
      ext_cnt_reg  <= ext_cnt_next;
      bus_req_reg  <= bus_req_next;
      halted_reg   <= halted_next;
    end
  end

  assign pins.cold_reset_in_n      = (cold_cnt_reg == 16'd0);
  assign pins.warm_reset_in_n      = (warm_cnt_reg == 16'd0);
  assign pins.ext_irq_in_n         = (ext_cnt_reg == 16'd0);
  assign pins.sysmgmt_irq_in_n     = !smi_req;
  assign pins.mach_check_in_n      = !mcp_req;
  assign pins.transfer_error_ack_n = !tea_req;
  assign pins.addr_parity_err_n    = !ape_req;
  assign pins.data_parity_err_n    = !dpe_req;
  assign pins.halt_in_n            = !halt_req;

  assign cold_busy   = (cold_cnt_reg != 16'd0);
  assign warm_busy   = (warm_cnt_reg != 16'd0);
  assign dev_bus_req = bus_req_reg;
  assign dev_halted  = halted_reg;

endmodule : xr_sys

/* xr_chk.sv */
/*
  checker for the pins between system logic and processor exception unit.
  assumes it is instantiated beside the interface, on the same clk and nrst.
*/
`timescale 1ns/1ps
module xr_chk #(
  parameter int COLD_LEN = 20,
  parameter int INIT_LEN = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cold_reset_in_n,
  input wire logic warm_reset_in_n,
  input wire logic ext_irq_in_n,
  input wire logic halt_in_n,
  input wire logic halt_out_oe,
  input wire logic bus_request_oe,
  input wire logic bus_request_in_n
);
  logic [15:0] low_reg, low_next;
  logic [7:0]  high_reg, high_next;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // high_reg saturates, so a long run never wraps back into the init window
  always_comb begin
    low_next  = cold_reset_in_n ? 16'h0000 : low_reg + 16'h0001;
    high_next = !cold_reset_in_n ? 8'h00 : (high_reg == 8'hFF) ? high_reg : high_reg + 8'h01;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      low_reg  <= 16'h0000;
      high_reg <= 8'h00;
    end else begin
      low_reg  <= low_next;
      high_reg <= high_next;
    end
  end

  AST_COLD_FLOAT: assert property ($fell(cold_reset_in_n) |-> ##[1:5]
    (!halt_out_oe && !bus_request_oe)) else $error("outputs still driven after cold reset");
  AST_COLD_HELD: assert property ((!cold_reset_in_n)[*5] |->
    (!halt_out_oe && !bus_request_oe)) else $error("output driven during cold reset");
  AST_BR_NEGATED: assert property ((!cold_reset_in_n)[*5] |-> bus_request_in_n)
    else $error("bus request seen during cold reset");
  AST_INIT_FLOAT: assert property ($rose(cold_reset_in_n) |->
    (!halt_out_oe && !bus_request_oe)[*4]) else $error("output driven right after cold reset");
  AST_COLD_WIDTH: assert property ($rose(cold_reset_in_n) |-> low_reg >= COLD_LEN)
    else $error("cold reset pulse too short");
  AST_WARM_WIDTH: assert property ($fell(warm_reset_in_n) |=> !warm_reset_in_n)
    else $error("warm reset pulse too short");
  AST_EXT_WIDTH: assert property ($fell(ext_irq_in_n) |-> (!ext_irq_in_n)[*3])
    else $error("external interrupt pulse too short");
  AST_HALT_SEEN: assert property ($fell(halt_in_n) && high_reg > INIT_LEN + 8 |->
    ##[1:5] halt_out_oe) else $error("halt input not recognised");
  AST_HALT_STAYS: assert property (halt_out_oe && cold_reset_in_n |=> halt_out_oe)
    else $error("halt output dropped without cold reset");
endmodule : xr_chk

/* tb_top.sv */
/*
  testbench: system end and processor end joined by the pin interface.
  assumes shortened cold reset and init counts; inputs change 1 ns after clk rises.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_top;
  import xr_pkg::*;
  localparam int CL = 20;
  localparam int IL = 4;
  logic clk = 1'b0, nrst = 1'b0;
  logic cold_req = 1'b0, warm_req = 1'b0, smi_req = 1'b0, ext_req = 1'b0, halt_req = 1'b0;
  logic [3:0] mc_src = 4'h0;
  logic [31:0] pc_in = 32'h1234_5678, msr_wdata = 32'h0000_0000;
  logic sync_exc_pending = 1'b0, msr_wr = 1'b0, bus_req_user = 1'b1;
  logic exc_take, halt_enabled, io_functional, halted;
  logic [31:0] exc_vector, save_pc_reg, save_state_reg, machine_state_reg;
  logic cold_busy, warm_busy, dev_bus_req, dev_halted, got;
  int fail_count = 0, check_count = 0, cyc_count = 0;

  xr_if ifc();
  xr_sys #(.COLD_LEN(CL)) i_xr_sys (.clk(clk), .nrst(nrst), .pins(ifc.sys),
    .cold_req(cold_req), .warm_req(warm_req), .smi_req(smi_req), .ext_req(ext_req),
    .mcp_req(mc_src[0]), .tea_req(mc_src[1]), .ape_req(mc_src[2]), .dpe_req(mc_src[3]),
    .halt_req(halt_req), .cold_busy(cold_busy), .warm_busy(warm_busy),
    .dev_bus_req(dev_bus_req), .dev_halted(dev_halted));
  xr_dev #(.INIT_LEN(IL)) i_xr_dev (.clk(clk), .nrst(nrst), .pins(ifc.dev), .pc_in(pc_in),
    .sync_exc_pending(sync_exc_pending), .msr_wr(msr_wr), .msr_wdata(msr_wdata),
    .bus_req_user(bus_req_user), .exc_take(exc_take), .exc_vector(exc_vector),
    .save_pc_reg(save_pc_reg), .save_state_reg(save_state_reg),
    .machine_state_reg(machine_state_reg), .halt_enabled(halt_enabled),
    .io_functional(io_functional), .halted(halted));
  xr_chk #(.COLD_LEN(CL), .INIT_LEN(IL)) i_xr_chk (.clk(clk), .nrst(nrst),
    .cold_reset_in_n(ifc.cold_reset_in_n), .warm_reset_in_n(ifc.warm_reset_in_n),
    .ext_irq_in_n(ifc.ext_irq_in_n), .halt_in_n(ifc.halt_in_n),
    .halt_out_oe(ifc.halt_out_oe), .bus_request_oe(ifc.bus_request_oe),
    .bus_request_in_n(ifc.bus_request_in_n));

  always #25 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cyc;
    @(posedge clk);
    #1;
  endtask : cyc
  task automatic wait_take(input int lim, output logic g);
    g = 1'b0;
    for (int i = 0; i < lim && !g; i++) begin
      cyc;
      if (exc_take === 1'b1) g = 1'b1;
    end
  endtask : wait_take
  task automatic wr_msr(input logic [31:0] v);
    cyc;
    msr_wr = 1'b1;
    msr_wdata = v;
    cyc;
    msr_wr = 1'b0;
  endtask : wr_msr
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  // cut a hang short well above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cyc_count++;
    if (cyc_count == 3000) begin
      fail_count++;
      end_sim;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) cyc;
    nrst = 1'b1;
    repeat (2) cyc;
    `CHK("cold_busy", 1'b1, cold_busy)
    `CHK("bus_request_in_n", 1'b1, ifc.bus_request_in_n)
    `CHK("io_functional", 1'b0, io_functional)
    wait_take(60, got);
    `CHK("reset take", 1'b1, got)
    `CHK("exc_vector", 32'hFFF0_0100, exc_vector)
    `CHK("msr", 32'h0000_0040, machine_state_reg)
    `CHK("halt_enabled", 1'b1, halt_enabled)
    `CHK("io_functional", 1'b1, io_functional)
    repeat (3) cyc;
    `CHK("dev_bus_req", 1'b1, dev_bus_req)
    // external request while disabled stays pending
    ext_req = 1'b1;
    cyc;
    ext_req = 1'b0;
    wait_take(12, got);
    `CHK("masked take", 1'b0, got)
    wr_msr(32'h0000_8070);
    wait_take(8, got);
    `CHK("ext take", 1'b1, got)
    `CHK("exc_vector", 32'hFFF0_0500, exc_vector)
    `CHK("save_pc", 32'h1234_5678, save_pc_reg)
    `CHK("msr", 32'h0000_0040, machine_state_reg)
    // both maskable requests, held back by a synchronous exception
    sync_exc_pending = 1'b1;
    smi_req = 1'b1;
    ext_req = 1'b1;
    cyc;
    ext_req = 1'b0;
    repeat (6) cyc;
    wr_msr(32'h0000_8040);
    wait_take(8, got);
    `CHK("take under sync", 1'b0, got)
    sync_exc_pending = 1'b0;
    wait_take(8, got);
    `CHK("smi take", 1'b1, got)
    `CHK("exc_vector", 32'hFFF0_1400, exc_vector)
    smi_req = 1'b0;
    repeat (4) cyc;
    wr_msr(32'h0000_8040);
    wait_take(8, got);
    `CHK("ext take", 1'b1, got)
    `CHK("exc_vector", 32'hFFF0_0500, exc_vector)
    // one short pulse while enabled is taken once only
    wr_msr(32'h0000_8040);
    ext_req = 1'b1;
    cyc;
    ext_req = 1'b0;
    wait_take(8, got);
    `CHK("pulse take", 1'b1, got)
    wr_msr(32'h0000_8040);
    wait_take(8, got);
    `CHK("second take", 1'b0, got)
    // warm reset saves state
    wr_msr(32'h0000_8070);
    pc_in = 32'h0000_2468;
    cyc;
    warm_req = 1'b1;
    cyc;
    `CHK("warm_busy", 1'b1, warm_busy)
    warm_req = 1'b0;
    wait_take(8, got);
    `CHK("warm take", 1'b1, got)
    `CHK("exc_vector", 32'hFFF0_0100, exc_vector)
    `CHK("save_pc", 32'h0000_2468, save_pc_reg)
    `CHK("save_state", 32'h0000_8070, save_state_reg)
    `CHK("msr", 32'h0000_0040, machine_state_reg)
    // each machine check source
    for (int k = 0; k < 4; k++) begin
      wr_msr(32'h0000_1040);
      mc_src = 4'h1 << k;
      wait_take(8, got);
      `CHK("mc take", 1'b1, got)
      `CHK("exc_vector", 32'hFFF0_0200, exc_vector)
      mc_src = 4'h0;
      repeat (4) cyc;
    end
    // machine check outranks warm reset on the same edge
    wr_msr(32'h0000_1040);
    // the warm pin lags its request by one clock, so both pins assert together
    warm_req = 1'b1;
    cyc;
    warm_req = 1'b0;
    mc_src = 4'h1;
    wait_take(8, got);
    `CHK("mc take", 1'b1, got)
    `CHK("exc_vector", 32'hFFF0_0200, exc_vector)
    mc_src = 4'h0;
    repeat (8) cyc;
    // halt holds until cold reset
    halt_req = 1'b1;
    repeat (6) cyc;
    `CHK("halted", 1'b1, halted)
    `CHK("dev_halted", 1'b1, dev_halted)
    halt_req = 1'b0;
    repeat (4) cyc;
    `CHK("halted", 1'b1, halted)
    cold_req = 1'b1;
    cyc;
    cold_req = 1'b0;
    repeat (5) cyc;
    `CHK("halt_out_n", 1'b1, ifc.halt_out_n)
    `CHK("bus_request_in_n", 1'b1, ifc.bus_request_in_n)
    wait_take(60, got);
    `CHK("exc_vector", 32'hFFF0_0100, exc_vector)
    `CHK("halted", 1'b0, halted)
    // machine check with recovery disabled stops the processor
    mc_src = 4'h1;
    repeat (5) cyc;
    `CHK("mc halted", 1'b1, halted)
    mc_src = 4'h0;
    end_sim;
  end
endmodule : tb_top
